// >>> core/asr_core.sv
`timescale 1ns/1ns
`default_nettype none

// Function
// - enabling transmitter queues one idle frame as preamble before data
// - transmit shifter is 11 bits; frame shifts out 10 bits, or 11 bits in nine-bit mode
// - free shifter loads waiting character on bit boundary, buffer empty flag sets
// - nothing waiting after stop bit sets transmit done, line idles high
// - clearing enable keeps driving until data, idle or break completes
// - break request pulse sends one full frame of zeros when shifter frees
// - break request still high at break load queues another break
// - toggling enable off then on queues one idle character
// - frame is zero start, eight or nine data LSB first, one stop
// - completed character fills empty buffer and sets full, else overrun
// - full flag clears by status read while set, then data read
// - input sampled at 16x; zero after three ones is a falling edge
// - start accepted if two of slots 3, 5, 7 are zero
// - bits decided by majority of slots 8, 9, 10; start stays zero
// - any disagreeing sample in frame sets noise flag on transfer
// - falling edges realign bit timing during the data and stop bits, not the start bit
// - framing error on non-break preloads edge history with three ones
// - while framing error flag set, no character reaches receive buffer
// - sleep bit suppresses receiver flags; hardware clears it on wakeup
// - idle wakeup after one full character time of idle level
// - idle count starts after start bit, or after stop bit if selected
// - address wakeup when received most significant bit is one
// - idle flag clears by status then data read; rearms on new character
module asr_core #(
  parameter int unsigned DIV_W      = 16,
  parameter int unsigned FIFO_DEPTH = 8
) (
  input  wire logic                  clk_i,
  input  wire logic                  sys_rst_i,
  input  wire logic [DIV_W-1:0]      baud_div_i,
  input  wire logic                  nine_bit_i,
  input  wire logic                  tx_enable_bit_i,
  input  wire logic                  break_request_bit_i,
  input  wire logic                  rx_on_bit_i,
  input  wire logic                  rx_sleep_set_i,
  input  wire logic                  wake_addr_i,
  input  wire logic                  idle_count_start_select_i,
  input  wire asr_pkg::asr_char_type tx_data_i,
  input  wire logic                  tx_valid_i,
  output logic                       tx_ready_o,
  input  wire logic                  status_rd_i,
  input  wire logic                  data_rd_i,
  output asr_pkg::asr_char_type      rx_data_o,
  output asr_pkg::asr_status_type    status_o,
  output logic                       rx_sleep_bit_o,
  input  wire logic                  serial_in_pin_i,
  output logic                       serial_out_pin_o,
  output logic                       serial_out_oe_n_o
);

  typedef enum logic [1:0] {
    RX_IDLE,
    RX_START,
    RX_BITS
  } asr_rx_state_type;

  logic                  sample_tick;
  asr_pkg::asr_char_type fifo_data;
  logic                  fifo_valid;
  logic                  fifo_ready;

  // Sample tick source
  asr_baud #(
    .DIV_W (DIV_W)
  ) u_baud (
    .clk_i         (clk_i),
    .sys_rst_i     (sys_rst_i),
    .divisor_i     (baud_div_i),
    .sample_tick_o (sample_tick)
  );

  // Transmit data queue ahead of the transmit buffer
  asr_fifo #(
    .WIDTH ($bits(asr_pkg::asr_char_type)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_i       (clk_i),
    .sys_rst_i   (sys_rst_i),
    .in_data_i   (tx_data_i),
    .in_valid_i  (tx_valid_i),
    .in_ready_o  (tx_ready_o),
    .out_data_o  (fifo_data),
    .out_valid_o (fifo_valid),
    .out_ready_i (fifo_ready)
  );

  // ---------------- Transmitter ----------------
  logic [3:0]            tx_div_q;
  logic [10:0]           tx_sh_q;
  logic [3:0]            tx_left_q;
  logic                  tx_done_q;
  logic                  pre_pend_q;
  logic                  brk_pend_q;
  logic                  te_q;
  logic                  sbk_q;
  asr_pkg::asr_char_type tx_buf_q;
  logic                  tx_full_q;

  logic        tx_bit_tick;
  logic        tx_free;
  logic        load_pre;
  logic        load_brk;
  logic        load_dat;
  logic [3:0]  flen;
  logic [10:0] data_frame;

  // Load decisions on each bit boundary, preamble first, then break, then data
  assign flen        = asr_pkg::frame_len(nine_bit_i);
  assign tx_bit_tick = sample_tick && (tx_div_q == asr_pkg::TX_DIV_LAST);
  assign tx_free     = tx_bit_tick && (tx_left_q <= 4'h1);
  assign load_pre    = tx_free && pre_pend_q && tx_enable_bit_i;
  assign load_brk    = tx_free && !load_pre && brk_pend_q;
  assign load_dat    = tx_free && !load_pre && !brk_pend_q && tx_full_q && tx_enable_bit_i;
  assign fifo_ready  = !tx_full_q;
  // Start bit, data LSB first, stop bit; 8-bit frame carries a spare one
  assign data_frame  = nine_bit_i ? {1'b1, tx_buf_q.ninth, tx_buf_q.data, 1'b0}
                                  : {2'b11, tx_buf_q.data, 1'b0};

  // Pin stays owned while enabled or anything remains to finish
  assign serial_out_pin_o  = (tx_left_q != 4'h0) ? tx_sh_q[0] : 1'b1;
  assign serial_out_oe_n_o = !(tx_enable_bit_i || (tx_left_q != 4'h0) || brk_pend_q);

  // Bit time divider and control edge history
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      tx_div_q <= '0;
      te_q     <= 1'b0;
      sbk_q    <= 1'b0;
    end else begin
      if (sample_tick) tx_div_q <= tx_div_q + 1'b1;
      te_q  <= tx_enable_bit_i;
      sbk_q <= break_request_bit_i;
    end
  end

  // Queued preamble and break requests
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      pre_pend_q <= 1'b0;
      brk_pend_q <= 1'b0;
    end else begin
      if (tx_enable_bit_i && !te_q) begin
        pre_pend_q <= 1'b1;
      end else if (load_pre) begin
        pre_pend_q <= 1'b0;
      end
      if (break_request_bit_i && !sbk_q) begin
        brk_pend_q <= 1'b1;
      end else if (load_brk) begin
        brk_pend_q <= break_request_bit_i;
      end
    end
  end

  // Transmit buffer, refilled from the queue when empty
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      tx_buf_q  <= '0;
      tx_full_q <= 1'b0;
    end else if (fifo_valid && fifo_ready) begin
      tx_buf_q  <= fifo_data;
      tx_full_q <= 1'b1;
    end else if (load_dat) begin
      tx_full_q <= 1'b0;
    end
  end

  // Shifter and transmit done flag
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      tx_sh_q   <= asr_pkg::SH_IDLE;
      tx_left_q <= '0;
      tx_done_q <= 1'b1;
    end else if (load_pre || load_brk || load_dat) begin
      tx_sh_q   <= load_pre ? asr_pkg::SH_IDLE : (load_brk ? asr_pkg::SH_BREAK : data_frame);
      tx_left_q <= flen;
      tx_done_q <= 1'b0;
    end else if (tx_free) begin
      tx_left_q <= '0;
      if (tx_left_q == 4'h1) tx_done_q <= 1'b1;
    end else if (tx_bit_tick) begin
      tx_sh_q   <= {1'b1, tx_sh_q[10:1]};
      tx_left_q <= tx_left_q - 1'b1;
    end
  end

  // ---------------- Receiver ----------------
  logic             rx_meta_q;
  logic             rx_sync_q;
  logic [2:0]       hist_q;
  asr_rx_state_type rx_st_q;
  logic [4:0]       slot_q;
  logic [3:0]       bit_idx_q;
  logic [1:0]       zeros_q;
  logic [1:0]       ones_q;
  logic             noisy_q;
  logic             brk_q;
  logic [8:0]       rx_sh_q;
  logic [7:0]       idle_cnt_q;
  logic             idle_armed_q;
  logic             rd_seen_q;
  logic             sleep_q;
  asr_pkg::asr_char_type  rx_buf_q;
  logic             rx_full_flag_q;
  logic             or_q;
  logic             nf_q;
  logic             fe_q;
  logic             idle_q;

  logic       rx_tick;
  logic       smp;
  logic       fall_edge;
  logic [3:0] nbits;
  logic       vote;
  logic       stop_slot;
  logic       frame_done;
  logic       frame_fe;
  logic       frame_nf;
  logic       frame_brk;
  logic [8:0] frame_sh;
  asr_pkg::asr_char_type frame_char;
  logic       frame_msb;
  logic       awake;
  logic       deliver;
  logic       load_rx;
  logic       set_or;
  logic       idle_count_on;
  logic       idle_hit;
  logic       clear_seq;
  logic       any_rx_flag;

  // Sampling and edge detection
  assign rx_tick   = sample_tick && rx_on_bit_i;
  assign smp       = rx_sync_q;
  assign fall_edge = (hist_q == asr_pkg::HIST_ONES) && !smp;
  assign nbits     = nine_bit_i ? asr_pkg::DATA_BITS_9 : asr_pkg::DATA_BITS_8;
  assign vote      = asr_pkg::majority(ones_q[1], ones_q[0], smp);
  assign stop_slot = (rx_st_q == RX_BITS) && (slot_q == asr_pkg::SLOT_M3) &&
                     (bit_idx_q == nbits + 4'h1);

  // Frame completion decode at the stop bit decision slot
  assign frame_done = rx_tick && stop_slot && !fall_edge;
  assign frame_fe   = !vote;
  assign frame_nf   = noisy_q || (ones_q != 2'b00 && ones_q != 2'b11) ||
                      (ones_q == 2'b11 && !smp) || (ones_q == 2'b00 && smp);
  assign frame_brk  = brk_q && !vote;
  assign frame_sh   = rx_sh_q;
  assign frame_char = nine_bit_i ? asr_pkg::asr_char_type'(frame_sh)
                                 : asr_pkg::asr_char_type'({1'b0, frame_sh[8:1]});
  assign frame_msb  = nine_bit_i ? frame_char.ninth : frame_char.data[7];

  // Transfer decisions: sleep, held framing error, overrun
  assign awake     = !sleep_q || (wake_addr_i && frame_msb);
  assign deliver   = frame_done && awake && !fe_q;
  assign load_rx   = deliver && !rx_full_flag_q;
  assign set_or    = deliver && rx_full_flag_q;

  // Idle detection counts high samples from the chosen start point
  assign idle_count_on = idle_count_start_select_i ? (rx_st_q == RX_IDLE)
                                                   : (rx_st_q != RX_START);
  assign idle_hit      = rx_tick && smp && idle_count_on &&
                         (idle_cnt_q == {flen, 4'h0} - 8'h01);

  // Two-step flag clearing
  assign any_rx_flag = rx_full_flag_q || idle_q || or_q || nf_q || fe_q;
  assign clear_seq   = data_rd_i && rd_seen_q;

  // Input synchroniser
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      rx_meta_q <= 1'b1;
      rx_sync_q <= 1'b1;
    end else begin
      rx_meta_q <= serial_in_pin_i;
      rx_sync_q <= rx_meta_q;
    end
  end

  // Edge search history
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      hist_q <= '0;
    end else if (frame_done && frame_fe && !frame_brk) begin
      hist_q <= asr_pkg::HIST_ONES;
    end else if (rx_tick) begin
      hist_q <= {hist_q[1:0], smp};
    end
  end

  // Receive sequencer: start qualification, bit slots and resync
  always_ff @(posedge clk_i) begin
    if (sys_rst_i || !rx_on_bit_i) begin
      rx_st_q   <= RX_IDLE;
      slot_q    <= asr_pkg::SLOT_FIRST;
      bit_idx_q <= '0;
      zeros_q   <= '0;
      ones_q    <= '0;
      noisy_q   <= 1'b0;
      brk_q     <= 1'b1;
      rx_sh_q   <= '0;
    end else if (rx_tick) begin
      if (fall_edge && rx_st_q != RX_START) begin
        slot_q <= asr_pkg::SLOT_EDGE_N;
        if (rx_st_q == RX_IDLE) begin
          rx_st_q <= RX_START;
          zeros_q <= '0;
          ones_q  <= '0;
          noisy_q <= 1'b0;
          brk_q   <= 1'b1;
        end
      end else begin
        slot_q <= (slot_q == asr_pkg::SLOT_LAST) ? asr_pkg::SLOT_FIRST : slot_q + 5'h01;
        case (rx_st_q)
          RX_START: begin
            if (slot_q == asr_pkg::SLOT_Q1 || slot_q == asr_pkg::SLOT_Q2) begin
              if (!smp) zeros_q <= zeros_q + 2'b01;
              else noisy_q <= 1'b1;
            end else if (slot_q == asr_pkg::SLOT_Q3) begin
              if (smp) noisy_q <= 1'b1;
              if (zeros_q + {1'b0, !smp} < 2'b10) rx_st_q <= RX_IDLE;
            end else if (slot_q >= asr_pkg::SLOT_M1 && slot_q <= asr_pkg::SLOT_M3) begin
              if (smp) noisy_q <= 1'b1; // start stays zero
            end else if (slot_q == asr_pkg::SLOT_LAST) begin
              rx_st_q   <= RX_BITS;
              bit_idx_q <= 4'h1;
            end
          end
          RX_BITS: begin
            if (slot_q == asr_pkg::SLOT_M1) begin
              ones_q <= {smp, 1'b0};
            end else if (slot_q == asr_pkg::SLOT_M2) begin
              ones_q[0] <= smp;
            end else if (slot_q == asr_pkg::SLOT_M3) begin
              if (frame_nf) noisy_q <= 1'b1;
              if (stop_slot) begin
                rx_st_q <= RX_IDLE;
              end else begin
                rx_sh_q <= nine_bit_i ? {vote, rx_sh_q[8:1]} : {vote, rx_sh_q[8:1]};
                if (vote) brk_q <= 1'b0;
              end
            end else if (slot_q == asr_pkg::SLOT_LAST) begin
              bit_idx_q <= bit_idx_q + 4'h1;
            end
          end
          default: begin
            rx_st_q <= RX_IDLE;
          end
        endcase
      end
    end
  end

  // Idle counter, saturating at one character time
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      idle_cnt_q <= '0;
    end else if (rx_tick) begin
      if (!smp || !idle_count_on) idle_cnt_q <= '0;
      else if (idle_cnt_q != {flen, 4'h0}) idle_cnt_q <= idle_cnt_q + 8'h01;
    end
  end

  // Sleep bit: software set wins over hardware wakeup
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      sleep_q <= 1'b0;
    end else if (rx_sleep_set_i) begin
      sleep_q <= 1'b1;
    end else if ((idle_hit && !wake_addr_i) || (frame_done && wake_addr_i && frame_msb)) begin
      sleep_q <= 1'b0;
    end
  end

  // Receive buffer and flags; a new event wins over the clear sequence
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      rx_buf_q     <= '0;
      rx_full_flag_q       <= 1'b0;
      or_q         <= 1'b0;
      nf_q         <= 1'b0;
      fe_q         <= 1'b0;
      idle_q       <= 1'b0;
      idle_armed_q <= 1'b0;
      rd_seen_q    <= 1'b0;
    end else begin
      if (status_rd_i && any_rx_flag) rd_seen_q <= 1'b1;
      else if (data_rd_i) rd_seen_q <= 1'b0;
      if (load_rx) begin
        rx_buf_q     <= frame_char;
        rx_full_flag_q       <= 1'b1;
        nf_q         <= frame_nf;
        fe_q         <= frame_fe;
        idle_armed_q <= 1'b1;
      end else if (clear_seq) begin
        rx_full_flag_q <= 1'b0;
        nf_q   <= 1'b0;
        fe_q   <= 1'b0;
      end
      if (set_or) or_q <= 1'b1;
      else if (clear_seq) or_q <= 1'b0;
      if (idle_hit && idle_armed_q && !sleep_q) begin
        idle_q       <= 1'b1;
        idle_armed_q <= 1'b0;
      end else if (clear_seq) begin
        idle_q <= 1'b0;
      end
    end
  end

  // Status and data outputs
  assign rx_data_o      = rx_buf_q;
  assign rx_sleep_bit_o = sleep_q;
  assign status_o       = '{tx_buffer_empty_flag: !tx_full_q,
                            tx_done:              tx_done_q,
                            rx_full_flag:         rx_full_flag_q,
                            idle:                 idle_q,
                            overrun:              or_q,
                            noise_flag:           nf_q,
                            framing_error_flag:   fe_q};

endmodule

`default_nettype wire

// >>> core/asr_pkg.sv
package asr_pkg;

  // Frame lengths in bit times, start and stop bits included
  localparam logic [3:0] FRAME_LEN_8 = 4'ha;
  localparam logic [3:0] FRAME_LEN_9 = 4'hb;
  // Data bits per character
  localparam logic [3:0] DATA_BITS_8 = 4'h8;
  localparam logic [3:0] DATA_BITS_9 = 4'h9;

  // Sample slots within one bit time, numbered 1 to 16
  localparam logic [4:0] SLOT_FIRST  = 5'h01;
  localparam logic [4:0] SLOT_EDGE_N = 5'h02;
  localparam logic [4:0] SLOT_Q1     = 5'h03;
  localparam logic [4:0] SLOT_Q2     = 5'h05;
  localparam logic [4:0] SLOT_Q3     = 5'h07;
  localparam logic [4:0] SLOT_M1     = 5'h08;
  localparam logic [4:0] SLOT_M2     = 5'h09;
  localparam logic [4:0] SLOT_M3     = 5'h0a;
  localparam logic [4:0] SLOT_LAST   = 5'h10;

  // Sample ticks per bit, as a wrap value of the transmit divider
  localparam logic [3:0] TX_DIV_LAST = 4'hf;
  // Edge search history that marks three ones in a row
  localparam logic [2:0] HIST_ONES   = 3'h7;
  // Shifter contents for preamble and break
  localparam logic [10:0] SH_IDLE    = 11'h7ff;
  localparam logic [10:0] SH_BREAK   = 11'h000;

  // Character as held in the buffers
  typedef struct packed {
    logic       ninth;
    logic [7:0] data;
  } asr_char_type;

  // Status flags shown to software
  typedef struct packed {
    logic tx_buffer_empty_flag;
    logic tx_done;
    logic rx_full_flag;
    logic idle;
    logic overrun;
    logic noise_flag;
    logic framing_error_flag;
  } asr_status_type;

  // Frame length for the selected data width
  function automatic logic [3:0] frame_len(input logic nine);
    frame_len = nine ? FRAME_LEN_9 : FRAME_LEN_8;
  endfunction

  // Majority of three samples
  function automatic logic majority(input logic a, input logic b, input logic c);
    majority = (a & b) | (a & c) | (b & c);
  endfunction

endpackage

// >>> core/asr_baud.sv
`timescale 1ns/1ns
`default_nettype none

// Divider producing the 16x sample tick from the bus clock
module asr_baud #(
  parameter int unsigned DIV_W = 16
) (
  input  wire logic             clk_i,
  input  wire logic             sys_rst_i,
  input  wire logic [DIV_W-1:0] divisor_i,
  output logic                  sample_tick_o
);

  logic [DIV_W-1:0] cnt_q;
  logic [DIV_W-1:0] cnt_d;
  logic             wrap;

  // Tick when the count reaches the divisor; zero divisor ticks every clock
  assign wrap          = (cnt_q >= divisor_i);
  assign cnt_d         = wrap ? '0 : cnt_q + 1'b1;
  assign sample_tick_o = wrap;

  // Divider count
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

endmodule

`default_nettype wire

// >>> core/asr_fifo.sv
`timescale 1ns/1ns
`default_nettype none

// Small synchronous FIFO with valid and ready on both sides
module asr_fifo #(
  parameter int unsigned WIDTH = 9,
  parameter int unsigned DEPTH = 8,
  parameter int unsigned AW    = $clog2(DEPTH)
) (
  input  wire logic             clk_i,
  input  wire logic             sys_rst_i,
  input  wire logic [WIDTH-1:0] in_data_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  output logic [WIDTH-1:0]      out_data_o,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i
);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [AW:0]      cnt_q;
  logic             push;
  logic             pop;
  logic [AW-1:0]    head_nx;

  // Full and empty from the occupancy count; head index after this edge
  assign in_ready_o  = (cnt_q < (AW+1)'(DEPTH));
  assign out_valid_o = (cnt_q != '0);
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;
  assign head_nx     = pop ? AW'(rd_q + 1'b1) : rd_q;

  // Storage, no reset needed
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_q[wr_q] <= in_data_i;
    end
  end

  // Read register follows the head; a word written into the head passes straight through
  always_ff @(posedge clk_i) begin
    out_data_o <= (push && (wr_q == head_nx)) ? in_data_i : mem_q[head_nx];
  end

  // Pointers and count
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) wr_q <= AW'(wr_q + 1'b1);
      if (pop) rd_q <= AW'(rd_q + 1'b1);
      cnt_q <= (AW+1)'(cnt_q + push - pop);
    end
  end

endmodule

`default_nettype wire

// >>> dv/asr_core_sva.sv
`timescale 1ns/1ns
`default_nettype none

// Port checks of the serial core
module asr_core_sva #(
  parameter int unsigned DIV_W = 16
) (
  input wire logic                    clk_i,
  input wire logic                    sys_rst_i,
  input wire logic                    tx_enable_bit_i,
  input wire logic                    data_rd_i,
  input wire asr_pkg::asr_char_type   rx_data_o,
  input wire asr_pkg::asr_status_type status_o,
  input wire logic                    rx_sleep_bit_o,
  input wire logic                    serial_out_pin_o,
  input wire logic                    serial_out_oe_n_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  // Full buffer with no data read pending
  sequence s_held;
    status_o.rx_full_flag && !data_rd_i;
  endsequence

  // Line and flag checks
  AST_RESET: assert property (disable iff (1'b0)
    sys_rst_i |=> status_o == 7'h60 && serial_out_pin_o) else $error("reset values wrong");
  AST_RELEASED_HIGH: assert property (serial_out_oe_n_o |-> serial_out_pin_o)
    else $error("released line not high");
  AST_ENABLE_DRIVES: assert property (tx_enable_bit_i |-> !serial_out_oe_n_o)
    else $error("pin not driven while enabled");
  AST_DONE_HIGH: assert property (status_o.tx_done |-> serial_out_pin_o)
    else $error("done with line low");
  AST_DONE_EMPTY: assert property ($rose(status_o.tx_done) |-> status_o.tx_buffer_empty_flag)
    else $error("done with data waiting");
  AST_OVERRUN: assert property ($rose(status_o.overrun) |->
    $past(status_o.rx_full_flag) && $stable(rx_data_o)) else $error("overrun touched data");
  AST_FULL_HOLDS: assert property (s_held |=> status_o.rx_full_flag)
    else $error("full flag lost without read");
  AST_FE_BLOCKS: assert property ($rose(status_o.rx_full_flag) |->
    !$past(status_o.framing_error_flag)) else $error("transfer while framing error");
  AST_SLEEP: assert property ($rose(status_o.rx_full_flag) |-> !rx_sleep_bit_o)
    else $error("flag set while asleep");
endmodule

bind asr_core asr_core_sva #(.DIV_W(DIV_W)) u_sva (
  .clk_i(clk_i), .sys_rst_i(sys_rst_i), .tx_enable_bit_i(tx_enable_bit_i),
  .data_rd_i(data_rd_i), .rx_data_o(rx_data_o), .status_o(status_o),
  .rx_sleep_bit_o(rx_sleep_bit_o), .serial_out_pin_o(serial_out_pin_o),
  .serial_out_oe_n_o(serial_out_oe_n_o)
);

`default_nettype wire

// >>> dv/asr_remote.sv
`timescale 1ns/1ns
`default_nettype none

// Remote transceiver: raw frames out LSB first, frames captured off the line
module asr_remote #(
  parameter int BIT_CLKS = 16
) (
  input  wire logic       clk_i,
  input  wire logic       line_i,
  input  wire logic       send_i,
  input  wire logic [9:0] frame_i,
  output logic            line_o,
  output logic            busy_o,
  output logic [9:0]      got_o,
  output logic [7:0]      got_cnt_o
);
  int         tx_ctr = 0;
  int         rx_ctr = 0;
  logic [9:0] tx_sh = '1;
  logic       rx_act = 1'b0;
  logic       line_q = 1'b1;

  // Line rests high between frames
  assign busy_o = tx_ctr != 0;
  assign line_o = busy_o ? tx_sh[9 - (tx_ctr - 1) / BIT_CLKS] : 1'b1;
  initial got_cnt_o = 8'h00;

  // Sender counts down one frame
  always_ff @(posedge clk_i) begin
    if (send_i && !busy_o) begin
      tx_sh <= frame_i;
      tx_ctr <= 10 * BIT_CLKS;
    end else if (busy_o) begin
      tx_ctr <= tx_ctr - 1;
    end
  end

  // Receiver samples mid bit after a falling edge
  always @(posedge clk_i) begin
    line_q <= line_i;
    if (!rx_act && line_q && !line_i) begin
      rx_act <= 1'b1;
      rx_ctr <= 1;
    end else if (rx_act) begin
      rx_ctr <= rx_ctr + 1;
      if (rx_ctr % BIT_CLKS == BIT_CLKS / 2) begin
        got_o[rx_ctr / BIT_CLKS] <= line_i;
        if (rx_ctr / BIT_CLKS == 9) begin
          rx_act <= 1'b0;
          got_cnt_o <= got_cnt_o + 8'h01;
        end
      end
    end
  end
endmodule

`default_nettype wire

// >>> dv/test_async_serial_tx_rx_wakeup.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin err_total++; \
  $display("[FAIL] %s exp %h got %h", n, e, g); end end

module test_async_serial_tx_rx_wakeup;
  logic clk_i = 0, rst = 1, ten = 0, brk = 0, slp = 0, wak = 0, vld = 0;
  logic srd = 0, drd = 0, snd = 0, trdy, sbit, txd, oe_n, rline, tline, rbusy;
  logic [9:0] frm = '1, got;
  logic [7:0] gcnt;
  asr_pkg::asr_char_type   tdat = '0, rdat;
  asr_pkg::asr_status_type st;
  int err_total = 0, samples_checked = 0;

  // Clock and pulled-up line seen by the remote
  initial forever #5 clk_i = ~clk_i;
  assign tline = oe_n ? 1'b1 : txd;

  asr_core uut (
    .clk_i(clk_i), .sys_rst_i(rst), .baud_div_i(16'h0000), .nine_bit_i(1'b0),
    .tx_enable_bit_i(ten), .break_request_bit_i(brk), .rx_on_bit_i(1'b1),
    .rx_sleep_set_i(slp), .wake_addr_i(wak), .idle_count_start_select_i(1'b0),
    .tx_data_i(tdat), .tx_valid_i(vld), .tx_ready_o(trdy), .status_rd_i(srd),
    .data_rd_i(drd), .rx_data_o(rdat), .status_o(st), .rx_sleep_bit_o(sbit),
    .serial_in_pin_i(rline), .serial_out_pin_o(txd), .serial_out_oe_n_o(oe_n)
  );
  asr_remote #(.BIT_CLKS(16)) u_remote (
    .clk_i(clk_i), .line_i(tline), .send_i(snd), .frame_i(frm),
    .line_o(rline), .busy_o(rbusy), .got_o(got), .got_cnt_o(gcnt)
  );

  task automatic conclude();
    if (err_total == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic tk(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic bound(input logic ok);
    if (!ok) begin
      err_total++;
      conclude();
    end
  endtask
  task automatic wcnt(input logic [7:0] n);
    for (int i = 0; i < 2000 && gcnt != n; i++) tk(1);
    bound(gcnt == n);
  endtask
  task automatic sendf(input logic [9:0] f);
    frm = f;
    snd = 1;
    tk(1);
    snd = 0;
    for (int i = 0; i < 400 && rbusy; i++) tk(1);
    bound(!rbusy);
    tk(4);
  endtask
  task automatic clr();
    srd = 1;
    tk(1);
    srd = 0;
    drd = 1;
    tk(1);
    drd = 0;
  endtask

  task automatic t_tx();
    int n;
    ten = 1;
    tdat = 9'h0a5;
    vld = 1;
    `CHK("ready", 1'b1, trdy)
    tk(1);
    tdat = 9'h13c;
    tk(1);
    vld = 0;
    for (n = 2; n < 400 && txd; n++) tk(1);
    `CHK("preamble", 1'b1, n > 161 && n < 178)
    wcnt(8'h01);
    `CHK("frame1", 10'h34a, got)
    wcnt(8'h02);
    `CHK("frame2", 10'h278, got)
    for (n = 0; n < 100 && st.tx_done !== 1'b1; n++) tk(1);
    `CHK("done", 2'b11, {st.tx_done, txd})
  endtask
  task automatic t_brk();
    brk = 1;
    for (int i = 0; i < 100 && txd; i++) tk(1);
    brk = 0;
    ten = 0;
    tk(40);
    `CHK("hold", 1'b0, oe_n)
    wcnt(8'h03);
    `CHK("break", 10'h000, got)
    tk(20);
    `CHK("break2", 2'b00, {oe_n, txd})
    tk(160);
    `CHK("release", 1'b1, oe_n)
  endtask
  task automatic t_rx();
    sendf(10'h278);
    `CHK("data", {1'b1, 9'h03c}, {st.rx_full_flag, rdat})
    sendf(10'h302);
    `CHK("overrun", {1'b1, 9'h03c}, {st.overrun, rdat})
    clr();
    `CHK("cleared", 7'h60, st)
    sendf(10'h0aa);
    `CHK("framing", 1'b1, st.framing_error_flag)
    tk(200);
    `CHK("fe_hold", {1'b1, 9'h055}, {st.framing_error_flag, rdat})
    `CHK("idle", 1'b1, st.idle)
    clr();
  endtask
  task automatic t_wake();
    wak = 1;
    slp = 1;
    tk(1);
    slp = 0;
    `CHK("asleep", 1'b1, sbit)
    sendf(10'h224);
    `CHK("quiet", 2'b01, {st.rx_full_flag, sbit})
    sendf(10'h324);
    `CHK("awake", {1'b0, 9'h092}, {sbit, rdat})
    clr();
    wak = 0;
    slp = 1;
    tk(1);
    slp = 0;
    sendf(10'h224);
    tk(170);
    `CHK("idle_wake", 3'b000, {sbit, st.rx_full_flag, st.idle})
  endtask

  // Reset, then each scenario in turn
  initial begin
    tk(6);
    rst = 0;
    tk(1);
    `CHK("reset", {7'h60, 3'b110}, {st, txd, oe_n, sbit})
    t_tx();
    t_brk();
    t_rx();
    t_wake();
    conclude();
  end
endmodule

`default_nettype wire
